/* File: logic/gap_timer.v */
// Purpose: down-counter that times one gap between strobes
// Assumes: count_in is at least 1
// Notes: done_out pulses one cycle while the count stands at 1, the cycle before it reaches 0
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.vh"

module gap_timer (
    input wire ref_clk_in,
    input wire rst_b_in,
    input wire load_in,
    input wire [`GAP_CNT_W-1:0] count_in,
    output wire done_out
);
    reg [`GAP_CNT_W-1:0] cnt_reg;
    reg [`GAP_CNT_W-1:0] cnt_next;

    always @* begin
        cnt_next = cnt_reg;
        if (load_in) begin
            cnt_next = count_in;
        end else if (cnt_reg != {`GAP_CNT_W{1'b0}}) begin
            cnt_next = cnt_reg - {{(`GAP_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            cnt_reg <= {`GAP_CNT_W{1'b0}};
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done_out = !load_in && (cnt_reg == {{(`GAP_CNT_W-1){1'b0}}, 1'b1});
endmodule // gap_timer

`default_nettype wire

/* File: logic/rail_seq_defs.vh */
// Purpose: shared constants of the rail sequencer timing core
// Assumes: 200 MHz core clock
// Notes: definitions only
`ifndef RAIL_SEQ_DEFS_VH
`define RAIL_SEQ_DEFS_VH

`define ADDR_DELAY_SELECT_LOW 8'h20
`define ADDR_DELAY_SELECT_HIGH 8'h21
`define ADDR_BUCK_STROBE_ASSIGN 8'h22

`define RST_DELAY_SELECT_LOW 8'h00
`define RST_DELAY_SELECT_HIGH 8'h00
`define RST_BUCK_STROBE_ASSIGN 8'h86

`define BIT_GAP_SEL_9 0
`define BIT_DOWN_MULT 7
`define BUCK_TWO_MSB 7
`define BUCK_TWO_LSB 4
`define BUCK_ONE_MSB 3
`define BUCK_ONE_LSB 0

`define ASSIGN_FIRST 4'h3
`define ASSIGN_LAST 4'ha
`define STROBE_FIRST 4'h1
`define STROBE_LAST 4'ha

`define CLK_FREQ_KHZ 24'h030d40
`define GAP_SHORT_MS 24'h000002
`define GAP_LONG_MS 24'h000005
`define DOWN_MULT 24'h00000a
`define GAP_SHORT_CYC (`GAP_SHORT_MS * `CLK_FREQ_KHZ)
`define GAP_LONG_CYC (`GAP_LONG_MS * `CLK_FREQ_KHZ)
`define GAP_CNT_W 24

`endif

/* File: logic/rail_sequencer_timing_config.v */
// Purpose: timing and configuration core of the power-rail sequencer
// Assumes: register port is decoded upstream from the serial interface; all inputs on ref_clk_in
// Notes: power-down walks the strobes in reverse and turns rails off at their strobe
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.vh"

// Notes on behaviour
// - after strobe n and before strobe n+1 (n = 1..9) a gap of 2 ms, or 5 ms when its select bit is set, is timed.
// - gap selects one to eight sit in the first delay register, gap n at bit n-1.
// - the ninth gap select, between strobe 9 and 10, is bit 0 of the second delay register.
// - bit 7 of the second delay register set makes every gap ten times longer during power-down.
// - that multiplier is ignored during power-up, so power-up gaps stay 2 ms or 5 ms.
// - bits 6 to 1 of the second delay register are read-only and read as zero.
// - an assignment code of 3h to Ah enables the rail at strobe 3 to strobe 10.
// - an assignment code of 0h, 1h, 2h or Bh to Fh leaves the rail out of sequencer control.
// - the buck-two code sits in bits 7:4 and buck-one in bits 3:0 of the third register, reset 0x86.
// - the first delay register is at subaddress 0x20 and resets to 0x00.
// - the second delay register is at subaddress 0x21 and resets to 0x00.
module rail_sequencer_timing_config #(
    parameter [`GAP_CNT_W-1:0] GAP_SHORT_CYCLES = `GAP_SHORT_CYC,
    parameter [`GAP_CNT_W-1:0] GAP_LONG_CYCLES = `GAP_LONG_CYC
) (
    input wire ref_clk_in,
    input wire rst_b_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire unlock_in,
    input wire power_up_in,
    input wire power_down_in,
    output reg [7:0] reg_rdata_out,
    output wire unlock_armed_out,
    output wire [9:0] strobe_out,
    output wire [3:0] strobe_num_out,
    output wire seq_busy_out,
    output wire seq_down_out,
    output wire buck_one_en_out,
    output wire buck_two_en_out
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_UP_GAP = 2'd1;
    localparam [1:0] ST_DOWN_GAP = 2'd2;

    localparam [`GAP_CNT_W-1:0] DOWN_MULT_W = `DOWN_MULT;
    localparam [7:0] RST_HIGH_BITS = `RST_DELAY_SELECT_HIGH;

    reg [7:0] strobe_delay_select_low_reg;
    reg gap_sel_9_reg;
    reg power_down_gap_multiplier_reg;
    reg [7:0] buck_one_two_strobe_assign_reg;
    reg unlock_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] strobe_reg;
    reg [3:0] strobe_next;
    reg strobe_fire_reg;
    reg strobe_fire_next;
    reg buck_one_en_reg;
    reg buck_two_en_reg;
    reg timer_load;
    reg [`GAP_CNT_W-1:0] timer_count;
    reg [3:0] gap_index;
    reg gap_long;

    wire [8:0] gap_sel;
    wire protected_wr;
    wire timer_done;
    wire buck_one_hit;
    wire buck_two_hit;
    wire [`GAP_CNT_W-1:0] gap_base;
    wire [`GAP_CNT_W-1:0] gap_scaled;

    // password gate: one unlock arms exactly one write, set wins over consume
    assign protected_wr = reg_wr_in && unlock_reg;

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            unlock_reg <= 1'b0;
        end else if (unlock_in) begin
            unlock_reg <= 1'b1;
        end else if (reg_wr_in) begin
            unlock_reg <= 1'b0;
        end
    end

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            strobe_delay_select_low_reg <= `RST_DELAY_SELECT_LOW;
            gap_sel_9_reg <= RST_HIGH_BITS[`BIT_GAP_SEL_9];
            power_down_gap_multiplier_reg <= RST_HIGH_BITS[`BIT_DOWN_MULT];
            buck_one_two_strobe_assign_reg <= `RST_BUCK_STROBE_ASSIGN;
        end else if (protected_wr) begin
            case (reg_addr_in)
                `ADDR_DELAY_SELECT_LOW: begin
                    strobe_delay_select_low_reg <= reg_wdata_in;
                end
                `ADDR_DELAY_SELECT_HIGH: begin
                    gap_sel_9_reg <= reg_wdata_in[`BIT_GAP_SEL_9];
                    power_down_gap_multiplier_reg <= reg_wdata_in[`BIT_DOWN_MULT];
                end
                `ADDR_BUCK_STROBE_ASSIGN: begin
                    buck_one_two_strobe_assign_reg <= reg_wdata_in;
                end
                default: begin
                    strobe_delay_select_low_reg <= strobe_delay_select_low_reg;
                end
            endcase
        end
    end

    // read data is registered; unmapped subaddresses read zero
    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ADDR_DELAY_SELECT_LOW: begin
                    reg_rdata_out <= strobe_delay_select_low_reg;
                end
                `ADDR_DELAY_SELECT_HIGH: begin
                    reg_rdata_out <= {power_down_gap_multiplier_reg, 6'b000000, gap_sel_9_reg};
                end
                `ADDR_BUCK_STROBE_ASSIGN: begin
                    reg_rdata_out <= buck_one_two_strobe_assign_reg;
                end
                default: begin
                    reg_rdata_out <= 8'h00;
                end
            endcase
        end
    end

    // gap n follows strobe n; gap n select at bit n-1 of the low register, gap 9 in the high one
    assign gap_sel = {gap_sel_9_reg, strobe_delay_select_low_reg};

    // an explicit decode keeps the select defined when the index sits outside 1..9
    always @* begin
        gap_long = 1'b0;
        case (gap_index)
            4'h1: begin
                gap_long = gap_sel[0];
            end
            4'h2: begin
                gap_long = gap_sel[1];
            end
            4'h3: begin
                gap_long = gap_sel[2];
            end
            4'h4: begin
                gap_long = gap_sel[3];
            end
            4'h5: begin
                gap_long = gap_sel[4];
            end
            4'h6: begin
                gap_long = gap_sel[5];
            end
            4'h7: begin
                gap_long = gap_sel[6];
            end
            4'h8: begin
                gap_long = gap_sel[7];
            end
            4'h9: begin
                gap_long = gap_sel[8];
            end
            default: begin
                gap_long = 1'b0;
            end
        endcase
    end

    assign gap_base = gap_long ? GAP_LONG_CYCLES : GAP_SHORT_CYCLES;
    // truncation of the product is safe: 10 x 5 ms fits in 24 bits at 200 MHz
    assign gap_scaled = gap_base * DOWN_MULT_W;

    strobe_assign_decode u_buck_one_decode (
        .code_in(buck_one_two_strobe_assign_reg[`BUCK_ONE_MSB:`BUCK_ONE_LSB]),
        .strobe_in(strobe_reg),
        .controlled_out(),
        .hit_out(buck_one_hit)
    );

    strobe_assign_decode u_buck_two_decode (
        .code_in(buck_one_two_strobe_assign_reg[`BUCK_TWO_MSB:`BUCK_TWO_LSB]),
        .strobe_in(strobe_reg),
        .controlled_out(),
        .hit_out(buck_two_hit)
    );

    gap_timer u_gap_timer (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    always @* begin
        state_next = state_reg;
        strobe_next = strobe_reg;
        strobe_fire_next = 1'b0;
        timer_load = 1'b0;
        timer_count = gap_base;
        gap_index = strobe_reg;
        case (state_reg)
            ST_IDLE: begin
                // the last strobe of a run is still out here: a start is refused until it has gone
                if (power_up_in && !strobe_fire_reg) begin
                    strobe_next = `STROBE_FIRST;
                    strobe_fire_next = 1'b1;
                    state_next = ST_UP_GAP;
                end else if (power_down_in && !strobe_fire_reg) begin
                    strobe_next = `STROBE_LAST;
                    strobe_fire_next = 1'b1;
                    state_next = ST_DOWN_GAP;
                end
            end
            ST_UP_GAP: begin
                // gap after the strobe just fired; the multiplier is not used here
                timer_load = strobe_fire_reg;
                gap_index = strobe_reg;
                timer_count = gap_base;
                if (timer_done) begin
                    strobe_next = strobe_reg + 4'h1;
                    strobe_fire_next = 1'b1;
                    if (strobe_reg + 4'h1 == `STROBE_LAST) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_DOWN_GAP: begin
                // going down, the gap between strobe n and n-1 is gap n-1
                timer_load = strobe_fire_reg;
                gap_index = strobe_reg - 4'h1;
                timer_count = power_down_gap_multiplier_reg ? gap_scaled : gap_base;
                if (timer_done) begin
                    strobe_next = strobe_reg - 4'h1;
                    strobe_fire_next = 1'b1;
                    if (strobe_reg - 4'h1 == `STROBE_FIRST) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            state_reg <= ST_IDLE;
            strobe_reg <= 4'h0;
            strobe_fire_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            strobe_reg <= strobe_next;
            strobe_fire_reg <= strobe_fire_next;
        end
    end

    // the direction is latched from the start request while not busy, power-up winning over power-down
    reg going_down_reg;

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            going_down_reg <= 1'b0;
        end else if (!seq_busy_out && power_down_in && !power_up_in) begin
            going_down_reg <= 1'b1;
        end else if (!seq_busy_out && power_up_in) begin
            going_down_reg <= 1'b0;
        end
    end

    always @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            buck_one_en_reg <= 1'b0;
            buck_two_en_reg <= 1'b0;
        end else if (strobe_fire_reg) begin
            if (buck_one_hit) begin
                buck_one_en_reg <= !going_down_reg;
            end
            if (buck_two_hit) begin
                buck_two_en_reg <= !going_down_reg;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_strobe
            localparam [3:0] STROBE_NUM = gi + 1;
            assign strobe_out[gi] = strobe_fire_reg && (strobe_reg == STROBE_NUM);
        end
    endgenerate

    assign strobe_num_out = strobe_reg;
    assign seq_busy_out = (state_reg != ST_IDLE) || strobe_fire_reg;
    assign seq_down_out = going_down_reg;
    assign unlock_armed_out = unlock_reg;
    assign buck_one_en_out = buck_one_en_reg;
    assign buck_two_en_out = buck_two_en_reg;
endmodule // rail_sequencer_timing_config

`default_nettype wire

/* File: logic/strobe_assign_decode.v */
// Purpose: decodes one rail's four-bit strobe-assignment code
// Assumes: code comes straight from a register on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.vh"

module strobe_assign_decode (
    input wire [3:0] code_in,
    input wire [3:0] strobe_in,
    output wire controlled_out,
    output wire hit_out
);
    // codes below 3h and above Ah leave the rail alone
    assign controlled_out = (code_in >= `ASSIGN_FIRST) && (code_in <= `ASSIGN_LAST);
    assign hit_out = controlled_out && (code_in == strobe_in);
endmodule // strobe_assign_decode

`default_nettype wire

/* File: testbench/rail_seq_props.sv */
// Purpose: port assertions for the rail sequencer core
// Assumes: gap parameters equal those of the bound instance
// Notes: cnt_reg counts cycles since the last strobe
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.vh"
module rail_seq_props #(
    parameter [`GAP_CNT_W-1:0] GAP_SHORT_CYCLES = 24'd3,
    parameter [`GAP_CNT_W-1:0] GAP_LONG_CYCLES = 24'd7
) (
    input wire ref_clk_in,
    input wire rst_b_in,
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire unlock_in,
    input wire power_up_in,
    input wire power_down_in,
    input wire [7:0] reg_rdata_out,
    input wire unlock_armed_out,
    input wire [9:0] strobe_out,
    input wire seq_busy_out,
    input wire seq_down_out,
    input wire buck_one_en_out,
    input wire buck_two_en_out
);
    localparam int S = GAP_SHORT_CYCLES + 1;
    localparam int L = GAP_LONG_CYCLES + 1;
    int cnt_reg;
    logic [9:0] last_reg;
    // cleared while idle so the first strobe of a run is never timed
    always @(posedge ref_clk_in) begin
        if (!rst_b_in || !seq_busy_out)
            cnt_reg <= 0;
        else if (strobe_out != 10'h000)
            cnt_reg <= 1;
        else if (cnt_reg != 0)
            cnt_reg <= cnt_reg + 1;
        if (strobe_out != 10'h000)
            last_reg <= strobe_out;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_up_req; power_up_in && !seq_busy_out; endsequence
    sequence s_dn_req; power_down_in && !power_up_in && !seq_busy_out; endsequence
    sequence s_next; strobe_out != 10'h000 && cnt_reg != 0; endsequence
    a_up_first: assert property (s_up_req |=> strobe_out == 10'h001 && seq_busy_out)
        else $error("power-up did not open with strobe one");
    a_down_first: assert property (s_dn_req |=> strobe_out == 10'h200 && seq_down_out)
        else $error("power-down did not open with strobe ten");
    a_up_gap: assert property (s_next ##0 !seq_down_out |-> cnt_reg == S || cnt_reg == L)
        else $error("power-up strobe spacing off");
    a_down_gap: assert property (s_next ##0 seq_down_out |-> cnt_reg inside {S, L, 10*S-9, 10*L-9})
        else $error("power-down strobe spacing off");
    a_up_order: assert property (s_next ##0 !seq_down_out |-> strobe_out == (last_reg << 1))
        else $error("power-up strobe out of order");
    a_rsvd_zero: assert property (reg_rd_in && reg_addr_in == 8'h21 |=> reg_rdata_out[6:1] == 6'h00)
        else $error("reserved bits read nonzero");
    a_unlock_arm: assert property (unlock_in |=> unlock_armed_out)
        else $error("unlock not armed");
    a_unlock_use: assert property (reg_wr_in && unlock_armed_out && !unlock_in |=> !unlock_armed_out)
        else $error("unlock not consumed by write");
    a_rail_step: assert property ($past(rst_b_in) && ($changed(buck_one_en_out) || $changed(buck_two_en_out))
        |-> $past(strobe_out) != 10'h000)
        else $error("rail enable moved without a strobe");
endmodule // rail_seq_props
bind rail_sequencer_timing_config rail_seq_props #(.GAP_SHORT_CYCLES(GAP_SHORT_CYCLES),
    .GAP_LONG_CYCLES(GAP_LONG_CYCLES)) rail_seq_props_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .unlock_in(unlock_in),
    .power_up_in(power_up_in), .power_down_in(power_down_in), .reg_rdata_out(reg_rdata_out),
    .unlock_armed_out(unlock_armed_out), .strobe_out(strobe_out), .seq_busy_out(seq_busy_out),
    .seq_down_out(seq_down_out), .buck_one_en_out(buck_one_en_out), .buck_two_en_out(buck_two_en_out));
`default_nettype wire

/* File: testbench/reg_host.sv */
// Purpose: host software model on the register port
// Assumes: signals change 1 ns after a rising edge
// Notes: released address and data show the inverse value
`timescale 1ns/1ps
`default_nettype none
module reg_host (
    input wire logic ref_clk_in,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic unlock_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        unlock_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit unl);
        if (unl) begin
            @(posedge ref_clk_in);
            #1 unlock_out = 1'b1;
        end
        @(posedge ref_clk_in);
        #1 unlock_out = 1'b0;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(posedge ref_clk_in);
        #1 reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        #1 reg_rd_out = 1'b1;
        reg_addr_out = a;
        @(posedge ref_clk_in);
        #1 reg_rd_out = 1'b0;
        reg_addr_out = ~a;
    endtask
endmodule // reg_host
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the rail sequencer core
// Assumes: gaps shortened to 3 and 7 cycles
// Notes: read results go through exp_q
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk_in, rst_b_in, power_up_in, power_down_in, reg_wr, reg_rd, unlock, rd_d;
    logic armed, busy, down, en1, en2, e1, e2;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sh20, sh21, sh22, d;
    logic [9:0] strobe;
    logic [3:0] snum;
    logic [7:0] exp_q[$];
    integer num_errors = 0, check_count = 0, seed = 32'hc5acdd97, i;
    reg_host reg_host_inst (.ref_clk_in(ref_clk_in), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
        .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .unlock_out(unlock));
    rail_sequencer_timing_config #(.GAP_SHORT_CYCLES(24'd3), .GAP_LONG_CYCLES(24'd7))
        rail_sequencer_timing_config_inst (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .unlock_in(unlock), .power_up_in(power_up_in), .power_down_in(power_down_in),
        .reg_rdata_out(reg_rdata), .unlock_armed_out(armed), .strobe_out(strobe), .strobe_num_out(snum),
        .seq_busy_out(busy), .seq_down_out(down), .buck_one_en_out(en1), .buck_two_en_out(en2));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        reg_host_inst.rd(a);
    endtask
    task automatic wrx(input logic [7:0] a, input logic [7:0] v);
        reg_host_inst.wr(a, v, 1);
        if (a == 8'h20) sh20 = v;
        if (a == 8'h21) sh21 = v & 8'h81;
        if (a == 8'h22) sh22 = v;
    endtask
    // walks all ten strobes, timing each gap from the shadowed selects
    task automatic run_seq(input bit dn);
        integer k, n, g;
        logic [8:0] gs;
        gs = {sh21[0], sh20};
        n = 0;
        @(posedge ref_clk_in);
        #1 power_up_in = !dn;
        power_down_in = dn;
        @(posedge ref_clk_in);
        #1 power_up_in = 1'b0;
        power_down_in = 1'b0;
        for (k = 0; k < 10; k++) begin
            while (strobe === 10'h000 && n < 800) begin
                @(posedge ref_clk_in);
                #1 n++;
            end
            chk(strobe, dn ? 10'h200 >> k : 10'h001 << k, "strobe");
            chk(snum, dn ? 10 - k : k + 1, "strobe number");
            if (k > 0) chk(n, g, "gap");
            if (k < 9) g = ((dn ? gs[8-k] : gs[k]) ? 7 : 3) * ((dn && sh21[7]) ? 10 : 1) + 1;
            @(posedge ref_clk_in);
            #1 n = 1;
        end
        if (sh22[3:0] inside {[4'h3:4'ha]}) e1 = !dn;
        if (sh22[7:4] inside {[4'h3:4'ha]}) e2 = !dn;
        chk(busy, 1'b0, "busy");
        chk(en1, e1, "buck one");
        chk(en2, e2, "buck two");
    endtask
    always @(posedge ref_clk_in) begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1)
            chk(reg_rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx, "read");
    end
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        repeat (40000) @(posedge ref_clk_in);
        num_errors++;
        stop_test;
    end
    initial begin
        {rst_b_in, power_up_in, power_down_in, rd_d, e1, e2} = 6'h00;
        {sh20, sh21, sh22} = 24'h000086;
        repeat (10) @(posedge ref_clk_in);
        #1 rst_b_in = 1'b1;
        rdx(8'h20, 8'h00);
        rdx(8'h21, 8'h00);
        rdx(8'h22, 8'h86);
        rdx(8'h30, 8'h00);
        reg_host_inst.wr(8'h20, 8'hff, 0);
        rdx(8'h20, 8'h00);
        $display("test reset and lock done");
        for (i = 0; i < 3; i++) begin
            d = $random(seed);
            wrx(8'h20 + i[7:0], d | (i == 1 ? 8'h80 : 8'h00));
            rdx(8'h20 + i[7:0], i == 0 ? sh20 : i == 1 ? sh21 : sh22);
        end
        wrx(8'h22, 8'ha3);
        run_seq(0);
        run_seq(1);
        $display("test timing done");
        wrx(8'h21, sh21 & 8'h01);
        for (i = 0; i < 16; i++) begin
            wrx(8'h22, {4'hf - i[3:0], i[3:0]});
            run_seq(0);
            run_seq(1);
        end
        $display("test codes done");
        wrx(8'h22, 8'h53);
        run_seq(0);
        rst_b_in = 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1 rst_b_in = 1'b1;
        chk(en1, 1'b0, "reset buck one");
        chk(en2, 1'b0, "reset buck two");
        chk(snum, 4'h0, "reset strobe number");
        chk(busy, 1'b0, "reset busy");
        {e1, e2} = 2'b00;
        rdx(8'h22, 8'h86);
        rdx(8'h21, 8'h00);
        rdx(8'h20, 8'h00);
        repeat (3) @(posedge ref_clk_in);
        $display("test second reset done");
        stop_test;
    end
endmodule // tb
`default_nettype wire
